// file: design/cir_top.sv
// Card information registers with card-bus and chip-select serial access.
// ----------------------------------------------------------------------
// Summary of operation
// - In serial mode the reserved pin is an active-low chip select, the command pin is data in, the data pin a push-pull data out.
// - A reset command received with chip select low enters serial mode, otherwise the card stays in card-bus mode.
// - A 32-bit read-only operating-conditions register reports voltage window and power-up status.
// - Its bit 31 is the power-up status and bits 30 to 24 read zero.
// - Bits 23 to 15 read one for 2.7 to 3.6 V and bits 14 to 0 read zero.
// - A 128-bit read-only identity register, fixed at manufacture, is returned during identification.
// - Identity fields are maker 127-120, OEM 119-104, name 103-56, revision 55-48, serial 47-16, date 15-8, checksum 7-1, bit 0 one.
// - The identity register carries a 7-bit checksum over its upper contents.
// - A 16-bit relative-address register is loaded by the set-address command during initialization.
// - After identification the card answers addressed commands only when the address matches.
// - The relative address defaults to 0x0001.
// - Address 0x0000 is never assigned and a select command with it sends the card to standby.
// - The relative address reloads its default on power-up reset and on the go-idle command.
// - The relative address is write-only with no read path and is reassigned every initialization.
// - In serial mode the relative address is unavailable, conditions return 4 bytes, identity and specific data 16.
// - A 128-bit card-specific-data register is mostly read-only with a user programmable area, read by its own commands.
// ----------------------------------------------------------------------
`timescale 1ns/1ps
`include "cir_consts.svh"

module cir_top
    import cir_pkg::*;
#(
    parameter int          PWRUP_CYCLES = `CIR_PWRUP_CYC,
    parameter logic [7:0]  MAKER_CODE   = 8'h5a,       // Arbitrary value.
    parameter logic [15:0] OEM_CODE     = 16'h1234,    // Arbitrary value.
    parameter logic [47:0] PRODUCT_NAME = 48'h0,
    parameter logic [7:0]  PRODUCT_REV  = 8'h10,
    parameter logic [31:0] SERIAL_NUM   = 32'h1,
    parameter logic [7:0]  BUILD_DATE   = 8'h0,
    parameter logic [111:0] CSD_FIXED   = 112'h0
) (
    // Core clock and reset
    input  wire logic core_clk,
    input  wire logic rst_b,
    // Link clock from the host
    input  wire logic link_clk,
    // Pins
    input  wire logic reserved_pin_cs_b,
    input  wire logic serial_data_in,
    output logic      cmd_out,
    output logic      cmd_oe,
    output logic      serial_data_out,
    output logic      data_oe,
    // Status
    output logic      spi_mode,
    output logic      card_selected
);
    import cir_pkg::*;

    initial begin
        if (PWRUP_CYCLES < 1 || PWRUP_CYCLES > 65535) begin
            $error("cir_top: PWRUP_CYCLES out of range");
        end
    end

    // ------------------------------------------------------------------
    // Identity and specific data
    // ------------------------------------------------------------------
    logic [119:0] cid_body;
    logic [6:0]   cid_crc;
    logic [127:0] card_identity_reg;
    logic [7:0]   csd_prog;
    logic [6:0]   csd_crc;
    logic [127:0] card_specific_data_reg;
    logic [31:0]  operating_conditions_reg;

    assign cid_body = {MAKER_CODE, OEM_CODE, PRODUCT_NAME, PRODUCT_REV,
                       SERIAL_NUM, BUILD_DATE};

    cir_crc7 #(.WIDTH(120)) u_cid_crc (
        .data (cid_body),
        .crc  (cid_crc)
    );
    assign card_identity_reg = {cid_body, cid_crc, 1'b1};

    cir_crc7 #(.WIDTH(120)) u_csd_crc (
        .data ({CSD_FIXED, csd_prog}),
        .crc  (csd_crc)
    );
    assign card_specific_data_reg = {CSD_FIXED, csd_prog, csd_crc, 1'b1};

    // ------------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------------
    logic [5:0]   rx_cnt, next_rx_cnt;
    logic [46:0]  rx_sr, next_rx_sr;
    cir_cmd_t     cmd_word, next_cmd_word;
    logic         cmd_tgl, next_cmd_tgl;
    logic [135:0] tx_sr, next_tx_sr;
    logic [7:0]   tx_cnt, next_tx_cnt;
    logic [2:0]   rsp_s, mode_s;
    logic         rsp_seen, next_rsp_seen;
    logic         mode_lk, next_mode_lk;
    logic         next_cmd_out, next_cmd_oe, next_sdo, next_data_oe;
    logic [47:0]  frame_w;
    logic [6:0]   frame_crc;
    logic         frame_ok;
    logic         resp_tgl;
    cir_resp_t    resp;

    assign frame_w = {rx_sr, serial_data_in};

    cir_crc7 #(.WIDTH(40)) u_cmd_crc (
        .data (frame_w[47:8]),
        .crc  (frame_crc)
    );
    assign frame_ok = frame_w[`CIR_FR_TX_BIT] && frame_w[0] &&
                      (frame_crc == frame_w[`CIR_FR_CRC_HI:`CIR_FR_CRC_LO]);

    always_comb begin
        next_rx_cnt   = rx_cnt;
        next_rx_sr    = rx_sr;
        next_cmd_word = cmd_word;
        next_cmd_tgl  = cmd_tgl;
        next_tx_sr    = tx_sr;
        next_tx_cnt   = tx_cnt;
        next_rsp_seen = rsp_seen;
        next_mode_lk  = (mode_s[1] == mode_s[2]) ? mode_s[2] : mode_lk;
        next_cmd_out  = 1'b1;
        next_cmd_oe   = 1'b0;
        next_sdo      = 1'b1;
        next_data_oe  = mode_lk && !reserved_pin_cs_b;
        if (rx_cnt == 6'h00) begin
            // Frames are only taken while the line is ours to listen on.
            if (tx_cnt == 8'h00 && !serial_data_in &&
                (!mode_lk || !reserved_pin_cs_b)) begin
                next_rx_cnt = 6'h01;
                next_rx_sr  = frame_w[46:0];
            end
        end else if (mode_lk && reserved_pin_cs_b) begin
            next_rx_cnt = 6'h00;
        end else begin
            next_rx_sr = frame_w[46:0];
            if (rx_cnt == `CIR_FRAME_LAST) begin
                next_rx_cnt = 6'h00;
                if (frame_ok) begin
                    next_cmd_word.cs_low = !reserved_pin_cs_b;
                    next_cmd_word.index  = frame_w[`CIR_FR_IDX_HI:`CIR_FR_IDX_LO];
                    next_cmd_word.arg    = frame_w[`CIR_FR_ARG_HI:`CIR_FR_ARG_LO];
                    next_cmd_tgl         = !cmd_tgl;
                end
            end else begin
                next_rx_cnt = rx_cnt + 6'h01;
            end
        end
        if (rsp_s[1] == rsp_s[2] && rsp_s[2] != rsp_seen) begin
            next_rsp_seen = rsp_s[2];
            next_tx_sr    = resp.bits;
            next_tx_cnt   = resp.len;
        end else if (tx_cnt != 8'h00) begin
            next_tx_sr  = {tx_sr[134:0], 1'b0};
            next_tx_cnt = tx_cnt - 8'h01;
            if (mode_lk) begin
                next_sdo = tx_sr[135];
            end else begin
                next_cmd_out = tx_sr[135];
                next_cmd_oe  = 1'b1;
            end
        end
    end

    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_cnt          <= 6'h00;
            rx_sr           <= '0;
            cmd_word        <= '0;
            cmd_tgl         <= 1'b0;
            tx_sr           <= '0;
            tx_cnt          <= 8'h00;
            rsp_s           <= 3'h0;
            mode_s          <= 3'h0;
            rsp_seen        <= 1'b0;
            mode_lk         <= 1'b0;
            cmd_out         <= 1'b1;
            cmd_oe          <= 1'b0;
            serial_data_out <= 1'b1;
            data_oe         <= 1'b0;
        end else begin
            rx_cnt          <= next_rx_cnt;
            rx_sr           <= next_rx_sr;
            cmd_word        <= next_cmd_word;
            cmd_tgl         <= next_cmd_tgl;
            tx_sr           <= next_tx_sr;
            tx_cnt          <= next_tx_cnt;
            rsp_s           <= {rsp_s[1:0], resp_tgl};
            mode_s          <= {mode_s[1:0], spi_mode};
            rsp_seen        <= next_rsp_seen;
            mode_lk         <= next_mode_lk;
            cmd_out         <= next_cmd_out;
            cmd_oe          <= next_cmd_oe;
            serial_data_out <= next_sdo;
            data_oe         <= next_data_oe;
        end
    end

    // ------------------------------------------------------------------
    // Core domain
    // ------------------------------------------------------------------
    cir_state_t  st, next_st;
    logic [15:0] relative_address_reg, next_rca;
    logic        next_spi, next_sel, next_resp_tgl;
    logic [7:0]  next_csd_prog;
    logic [15:0] pwr_cnt, next_pwr;
    cir_resp_t   next_resp;
    logic [2:0]  cmd_s, next_cmd_s;
    logic        cmd_seen, next_cmd_seen;
    logic        cmd_new, pwr_done, addr_hit;

    assign cmd_new  = (cmd_s[1] == cmd_s[2]) && (cmd_s[2] != cmd_seen);
    assign pwr_done = (pwr_cnt == 16'(PWRUP_CYCLES));
    assign addr_hit = (cmd_word.arg[31:16] == relative_address_reg);
    assign operating_conditions_reg = `CIR_OCR_VOLT |
                                      (32'(pwr_done) << `CIR_OCR_BUSY_BIT);

    always_comb begin
        next_st       = st;
        next_rca      = relative_address_reg;
        next_spi      = spi_mode;
        next_csd_prog = csd_prog;
        next_resp     = resp;
        next_resp_tgl = resp_tgl;
        next_pwr      = pwr_done ? pwr_cnt : pwr_cnt + 16'h0001;
        next_cmd_s    = {cmd_s[1:0], cmd_tgl};
        next_cmd_seen = cmd_new ? cmd_s[2] : cmd_seen;
        if (cmd_new) begin
            case (cmd_word.index)
                `CIR_IDX_GO_IDLE: begin
                    next_st  = CIR_ST_IDLE;
                    next_rca = `CIR_RCA_DEFAULT;
                    next_spi = cmd_word.cs_low;
                end
                `CIR_IDX_SEND_OP: begin
                    if (!spi_mode && st == CIR_ST_IDLE) begin
                        next_resp     = '{{`CIR_RESP_HDR, operating_conditions_reg,
                                           `CIR_RESP_TAIL, 88'h0}, `CIR_LEN_R3};
                        next_resp_tgl = !resp_tgl;
                        if (pwr_done) begin
                            next_st = CIR_ST_READY;
                        end
                    end
                end
                `CIR_IDX_ALL_CID: begin
                    if (!spi_mode && st == CIR_ST_READY) begin
                        next_resp     = '{{`CIR_RESP_HDR, card_identity_reg}, `CIR_LEN_R2};
                        next_resp_tgl = !resp_tgl;
                        next_st       = CIR_ST_IDENT;
                    end
                end
                `CIR_IDX_SET_RCA: begin
                    if (!spi_mode && st == CIR_ST_IDENT &&
                        cmd_word.arg[31:16] != `CIR_RCA_NONE) begin
                        next_rca = cmd_word.arg[31:16];
                        next_st  = CIR_ST_STBY;
                    end
                end
                `CIR_IDX_SELECT: begin
                    if (!spi_mode && st == CIR_ST_STBY && addr_hit) begin
                        next_st = CIR_ST_TRAN;
                    end else if (!spi_mode && st == CIR_ST_TRAN && !addr_hit) begin
                        next_st = CIR_ST_STBY;
                    end
                end
                `CIR_IDX_SEND_CSD, `CIR_IDX_SEND_CID: begin
                    if (spi_mode) begin
                        next_resp.bits = (cmd_word.index == `CIR_IDX_SEND_CSD) ?
                                         {card_specific_data_reg, 8'h0} :
                                         {card_identity_reg, 8'h0};
                        next_resp.len  = `CIR_LEN_SPI_REG;
                        next_resp_tgl  = !resp_tgl;
                    end else if (st == CIR_ST_STBY && addr_hit) begin
                        next_resp.bits = (cmd_word.index == `CIR_IDX_SEND_CSD) ?
                                         {`CIR_RESP_HDR, card_specific_data_reg} :
                                         {`CIR_RESP_HDR, card_identity_reg};
                        next_resp.len  = `CIR_LEN_R2;
                        next_resp_tgl  = !resp_tgl;
                    end
                end
                `CIR_IDX_READ_OCR: begin
                    if (spi_mode) begin
                        next_resp     = '{{operating_conditions_reg, 104'h0},
                                          `CIR_LEN_SPI_OCR};
                        next_resp_tgl = !resp_tgl;
                    end
                end
                `CIR_IDX_PROG_CSD: begin
                    // Only the user area moves; its checksum follows it.
                    if (spi_mode || st == CIR_ST_TRAN) begin
                        next_csd_prog = cmd_word.arg[7:0];
                    end
                end
                default: begin
                end
            endcase
        end
        next_sel = (next_st == CIR_ST_TRAN);
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st                   <= CIR_ST_IDLE;
            relative_address_reg <= `CIR_RCA_DEFAULT;
            spi_mode             <= 1'b0;
            card_selected        <= 1'b0;
            csd_prog             <= 8'h00;
            resp                 <= '0;
            resp_tgl             <= 1'b0;
            pwr_cnt              <= 16'h0000;
            cmd_s                <= 3'h0;
            cmd_seen             <= 1'b0;
        end else begin
            st                   <= next_st;
            relative_address_reg <= next_rca;
            spi_mode             <= next_spi;
            card_selected        <= next_sel;
            csd_prog             <= next_csd_prog;
            resp                 <= next_resp;
            resp_tgl             <= next_resp_tgl;
            pwr_cnt              <= next_pwr;
            cmd_s                <= next_cmd_s;
            cmd_seen             <= next_cmd_seen;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_cmd(logic [5:0] idx);
        cmd_new && cmd_word.index == idx;
    endsequence

    property p_spi_entry;
        @(posedge core_clk) disable iff (!rst_b)
        s_cmd(`CIR_IDX_GO_IDLE) ##0 cmd_word.cs_low |=> spi_mode ##1 spi_mode;
    endproperty
    a_spi_entry: assert property (p_spi_entry) else $error("serial mode not entered");

    property p_rca_reset;
        @(posedge core_clk) disable iff (!rst_b)
        s_cmd(`CIR_IDX_GO_IDLE) |=> relative_address_reg == `CIR_RCA_DEFAULT && st == CIR_ST_IDLE;
    endproperty
    a_rca_reset: assert property (p_rca_reset) else $error("address not reset");

    property p_rca_load;
        @(posedge core_clk) disable iff (!rst_b)
        s_cmd(`CIR_IDX_SET_RCA) ##0 (!spi_mode && st == CIR_ST_IDENT && cmd_word.arg[31:16] != 16'h0)
        |=> relative_address_reg == $past(cmd_word.arg[31:16]) && st == CIR_ST_STBY;
    endproperty
    a_rca_load: assert property (p_rca_load) else $error("address not loaded");

    property p_rca_spi;
        @(posedge core_clk) disable iff (!rst_b)
        s_cmd(`CIR_IDX_SET_RCA) ##0 spi_mode |=> $stable(relative_address_reg);
    endproperty
    a_rca_spi: assert property (p_rca_spi) else $error("address moved in serial mode");

    property p_desel;
        @(posedge core_clk) disable iff (!rst_b)
        s_cmd(`CIR_IDX_SELECT) ##0 (!spi_mode && st == CIR_ST_TRAN && cmd_word.arg[31:16] == 16'h0)
        |=> st == CIR_ST_STBY && !card_selected;
    endproperty
    a_desel: assert property (p_desel) else $error("zero address did not deselect");

    property p_addr_only;
        @(posedge core_clk) disable iff (!rst_b)
        cmd_new && (cmd_word.index == `CIR_IDX_SEND_CSD || cmd_word.index == `CIR_IDX_SEND_CID) &&
        !spi_mode && !addr_hit |=> resp_tgl == $past(resp_tgl);
    endproperty
    a_addr_only: assert property (p_addr_only) else $error("answered foreign address");

    property p_cid_resp;
        @(posedge core_clk) disable iff (!rst_b)
        s_cmd(`CIR_IDX_ALL_CID) ##0 (!spi_mode && st == CIR_ST_READY)
        |=> resp.bits[127:120] == MAKER_CODE && resp.bits[0] && resp.len == `CIR_LEN_R2;
    endproperty
    a_cid_resp: assert property (p_cid_resp) else $error("identity answer malformed");

    property p_cid_crc;
        @(posedge core_clk) disable iff (!rst_b)
        s_cmd(`CIR_IDX_ALL_CID) ##0 (!spi_mode && st == CIR_ST_READY) |=> resp.bits[7:1] == cid_crc;
    endproperty
    a_cid_crc: assert property (p_cid_crc) else $error("identity checksum wrong");

    property p_ocr_rsvd;
        @(posedge core_clk) disable iff (!rst_b)
        s_cmd(`CIR_IDX_READ_OCR) ##0 spi_mode
        |=> resp.bits[134:128] == 7'h0 && resp.bits[135] == $past(pwr_done) && resp.len == 8'h20;
    endproperty
    a_ocr_rsvd: assert property (p_ocr_rsvd) else $error("conditions high bits wrong");

    property p_ocr_win;
        @(posedge core_clk) disable iff (!rst_b)
        s_cmd(`CIR_IDX_READ_OCR) ##0 spi_mode |=> resp.bits[127:104] == 24'hff8000;
    endproperty
    a_ocr_win: assert property (p_ocr_win) else $error("voltage window wrong");

    property p_spi_drive;
        @(posedge link_clk) disable iff (!rst_b)
        (mode_lk && !reserved_pin_cs_b) |=> data_oe && !cmd_oe;
    endproperty
    a_spi_drive: assert property (p_spi_drive) else $error("data out not driven");

endmodule

// file: design/cir_consts.svh
// Constants of the card information register block.
`ifndef CIR_CONSTS_SVH
`define CIR_CONSTS_SVH

// ----------------------------------------------------------------------
// Command indices
// ----------------------------------------------------------------------
`define CIR_IDX_GO_IDLE  6'h00
`define CIR_IDX_SEND_OP  6'h01
`define CIR_IDX_ALL_CID  6'h02
`define CIR_IDX_SET_RCA  6'h03
`define CIR_IDX_SELECT   6'h07
`define CIR_IDX_SEND_CSD 6'h09
`define CIR_IDX_SEND_CID 6'h0a
`define CIR_IDX_PROG_CSD 6'h1b
`define CIR_IDX_READ_OCR 6'h3a

// ----------------------------------------------------------------------
// Command frame layout, 48 bits, first bit sent is bit 47
// ----------------------------------------------------------------------
`define CIR_FRAME_LAST   6'h2f
`define CIR_FR_TX_BIT    46
`define CIR_FR_IDX_HI    45
`define CIR_FR_IDX_LO    40
`define CIR_FR_ARG_HI    39
`define CIR_FR_ARG_LO    8
`define CIR_FR_CRC_HI    7
`define CIR_FR_CRC_LO    1

// ----------------------------------------------------------------------
// Register contents and fields
// ----------------------------------------------------------------------
`define CIR_OCR_VOLT     32'h00ff8000
`define CIR_OCR_BUSY_BIT 31
`define CIR_RCA_DEFAULT  16'h0001
`define CIR_RCA_NONE     16'h0000
`define CIR_CID_MID_HI   127
`define CIR_CID_MID_LO   120
`define CIR_CRC_HI       7
`define CIR_CRC_LO       1
`define CIR_CRC7_POLY    7'h09

// ----------------------------------------------------------------------
// Responses, left aligned in a 136-bit word
// ----------------------------------------------------------------------
`define CIR_RESP_HDR     8'h3f
`define CIR_RESP_TAIL    8'hff
`define CIR_LEN_R3       8'h30
`define CIR_LEN_R2       8'h88
`define CIR_LEN_SPI_OCR  8'h20
`define CIR_LEN_SPI_REG  8'h80

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CIR_CORE_CLK_MHZ 125
`define CIR_PWRUP_US     8
`define CIR_PWRUP_CYC    (`CIR_PWRUP_US * `CIR_CORE_CLK_MHZ)

`endif

// file: design/cir_pkg.sv
// Types shared by the card information register block.
package cir_pkg;

    typedef enum logic [2:0] {
        CIR_ST_IDLE,
        CIR_ST_READY,
        CIR_ST_IDENT,
        CIR_ST_STBY,
        CIR_ST_TRAN
    } cir_state_t;

    typedef struct packed {
        logic        cs_low;
        logic [5:0]  index;
        logic [31:0] arg;
    } cir_cmd_t;

    typedef struct packed {
        logic [135:0] bits;
        logic [7:0]   len;
    } cir_resp_t;

endpackage

// file: design/cir_crc7.sv
// Combinational 7-bit checksum over a word, most significant bit first.
`timescale 1ns/1ps
`include "cir_consts.svh"

module cir_crc7 #(
    parameter int WIDTH = 120
) (
    // Data in
    input  wire logic [WIDTH-1:0] data,
    // Checksum out
    output logic      [6:0]       crc
);

    initial begin
        if (WIDTH < 1) begin
            $error("cir_crc7: WIDTH must be at least 1");
        end
    end

    // Generator x^7 + x^3 + 1, zero start value.
    always_comb begin
        logic [6:0] acc;
        logic       fb;
        acc = 7'h00;
        fb  = 1'b0;
        for (int i = WIDTH - 1; i >= 0; i--) begin
            fb  = data[i] ^ acc[6];
            acc = {acc[5:0], 1'b0};
            if (fb) begin
                acc = acc ^ `CIR_CRC7_POLY;
            end
        end
        crc = acc;
    end

endmodule

// file: testbench/cir_host_model.sv
// Host controller model: clocks the link, sends command frames and records the card's answer.
`timescale 1ns/1ps

module cir_host_model (
    // Host driven pins
    output logic      link_clk          = 1'b0,
    output logic      reserved_pin_cs_b = 1'b1,
    output logic      serial_data_in    = 1'b1,
    // Card driven pins
    input  wire logic cmd_out,
    input  wire logic cmd_oe,
    input  wire logic serial_data_out,
    input  wire logic data_oe
);
    logic [199:0] cap = '0;

    function automatic logic [6:0] crc7(input logic [119:0] d, input int n);
        crc7 = 7'h00;
        for (int i = 119; i > 119 - n; i--) begin
            crc7 = {crc7[5:0], 1'b0} ^ ((crc7[6] ^ d[i]) ? 7'h09 : 7'h00);
        end
    endfunction

    // Idle clocks with nothing sent, so that the card's link logic sees edges in reset.
    task automatic tick(input int n);
        repeat (n) begin
            #24 link_clk = 1'b1;
            #24 link_clk = 1'b0;
        end
    endtask

    // The clock stands still between frames; the last 200 edges after the end bit are kept.
    task automatic send(input logic cs_low, input logic [5:0] idx, input logic [31:0] arg, input logic bad);
        logic [47:0] fr;
        fr = {2'b01, idx, arg, 8'h01};
        fr[7:1] = crc7({fr[47:8], 80'h0}, 40) ^ {6'h00, bad};
        reserved_pin_cs_b = ~cs_low;
        serial_data_in = fr[47];
        for (int i = 46; i >= -200; i--) begin
            #24 link_clk = 1'b1;
            // A released command line floats to its pull-up; a released data line shows the inverse.
            cap <= {cap[198:0], cs_low ? (data_oe ? serial_data_out : ~serial_data_out) : (cmd_oe ? cmd_out : 1'b1)};
            serial_data_in <= (i >= 0) ? fr[i] : 1'b1;
            #24 link_clk = 1'b0;
        end
        reserved_pin_cs_b = 1'b1;
    endtask
endmodule

// file: testbench/cir_top_tb.sv
// Self-checking bench for the card information registers.
`timescale 1ns/1ps

module cir_top_tb;
    localparam logic [31:0]  OPERATING_CONDITIONS  = 32'h80ff8000;
    localparam logic [119:0] CIDH = {8'h3c, 16'h1234, 48'h0, 8'h10, 32'h0badcafe, 8'h00};
    logic         core_clk = 1'b0;
    logic         rst_b    = 1'b0;
    logic         link_clk, reserved_pin_cs_b, serial_data_in;
    logic         cmd_out, cmd_oe, serial_data_out, data_oe, spi_mode, card_selected;
    logic [127:0] card_identity;
    logic [127:0] spec_word;
    int           err_total   = 0;
    int           comparisons = 0;

    cir_top #(.PWRUP_CYCLES(20), .MAKER_CODE(8'h3c), .SERIAL_NUM(32'h0badcafe)) dut_u (.*);
    cir_host_model host_u (.link_clk, .reserved_pin_cs_b, .serial_data_in, .cmd_out, .cmd_oe,
                           .serial_data_out, .data_oe);

    initial begin
        forever #4 core_clk = ~core_clk;
    end

    task automatic chk(input logic [135:0] seen, input logic [135:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic quiet;
        chk({135'h0, &host_u.cap}, 136'h1);
    endtask

    // The answer may start a few edges late, so each of the first 16 offsets behind idle ones is tried.
    function automatic logic [135:0] pick(input int len, input logic [135:0] exp);
        logic [135:0] w;
        pick = 'x;
        for (int off = 0; off < 16; off++) begin
            w = '0;
            for (int b = 0; b < len; b++) w[len-1-b] = host_u.cap[199-off-b];
            if (w === exp) pick = w;
            if (host_u.cap[199-off] !== 1'b1) break;
        end
    endfunction

    task automatic end_of_test;
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        card_identity = {CIDH, host_u.crc7(CIDH, 120), 1'b1};
        fork
            repeat (5) @(posedge core_clk);
            host_u.tick(2);
        join
        @(posedge core_clk) rst_b <= 1'b1;
        host_u.send(1'b0, 6'h01, 32'h0, 1'b0);
        chk(pick(48, {8'h3f, OPERATING_CONDITIONS, 8'hff}), {8'h3f, OPERATING_CONDITIONS, 8'hff});
        host_u.send(1'b0, 6'h02, 32'h0, 1'b1);
        quiet();
        host_u.send(1'b0, 6'h02, 32'h0, 1'b0);
        chk(pick(136, {8'h3f, card_identity}), {8'h3f, card_identity});
        host_u.send(1'b0, 6'h03, 32'h00070000, 1'b0);
        quiet();
        host_u.send(1'b0, 6'h0a, 32'h00010000, 1'b0);
        quiet();
        host_u.send(1'b0, 6'h0a, 32'h00070000, 1'b0);
        chk(pick(136, {8'h3f, card_identity}), {8'h3f, card_identity});
        host_u.send(1'b0, 6'h07, 32'h00070000, 1'b0);
        chk({135'h0, card_selected}, 136'h1);
        host_u.send(1'b0, 6'h07, 32'h0, 1'b0);
        chk({135'h0, card_selected}, 136'h0);
        host_u.send(1'b0, 6'h00, 32'h0, 1'b0);
        chk({135'h0, spi_mode}, 136'h0);
        host_u.send(1'b1, 6'h00, 32'h0, 1'b0);
        chk({135'h0, spi_mode}, 136'h1);
        host_u.send(1'b1, 6'h3a, 32'h0, 1'b0);
        chk(pick(32, OPERATING_CONDITIONS), OPERATING_CONDITIONS);
        host_u.send(1'b1, 6'h0a, 32'h0, 1'b0);
        chk(pick(128, card_identity), card_identity);
        host_u.send(1'b1, 6'h09, 32'h0, 1'b0);
        chk(pick(128, 128'h1), 128'h1);
        host_u.send(1'b1, 6'h1b, 32'h000000a5, 1'b0);
        quiet();
        spec_word = {112'h0, 8'ha5, host_u.crc7({112'h0, 8'ha5}, 120), 1'b1};
        host_u.send(1'b1, 6'h09, 32'h0, 1'b0);
        chk(pick(128, spec_word), spec_word);
        host_u.send(1'b1, 6'h03, 32'h00070000, 1'b0);
        quiet();
        end_of_test();
    end
endmodule
